// *** bench/rsi_reset_source.sv ***
// Board reset source model: free-running crystal clock and an active-low reset pin.
`timescale 1ns/1ns
// ============================================================================
// Reset source
module rsi_reset_source (
  output logic resetPinN,
  output logic xinPin
);
  // Crystal half period of 8 system cycles, slow enough for the 3-flop sampler.
  localparam int XIN_HALF_NS = 400;

  // The reset pin idles high and the crystal idles low until the first toggle.
  initial begin
    resetPinN = 1'b1;
    xinPin = 1'b0;
  end

  // The crystal runs free, as a real oscillator does, with no frame gating.
  always #XIN_HALF_NS xinPin = ~xinPin;

  // Holds reset low for a whole number of crystal periods, starting at a falling crystal edge.
  // Callers pass more than four periods for a real reset, fewer for a glitch.
  task automatic hold_reset(input int periods);
    @(negedge xinPin);
    resetPinN = 1'b0;
    repeat (periods) @(negedge xinPin);
    resetPinN = 1'b1;
  endtask : hold_reset
endmodule : rsi_reset_source

// *** bench/rsi_reset_state_init_sva.sv ***
// Checker of processor and pin state around reset, bound to the register core.
`timescale 1ns/1ns
// ============================================================================
// Checker
module rsi_reset_state_init_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [rsi_pkg::PIN_COUNT-1:0] sharedPinOe,
  input wire logic [rsi_pkg::PORT_COUNT-1:0] portPinOe,
  input wire logic extModePin,
  input wire logic bootModePin,
  input wire logic backupOkPin,
  input wire logic cpuRun,
  input wire logic fetchStart,
  input wire logic [rsi_pkg::DATA_W-1:0] programCounter,
  input wire logic [rsi_pkg::DATA_W-1:0] processorStatusWord,
  input wire logic [rsi_pkg::DATA_W-1:0] conditionBitRegister,
  input wire logic ramRetained
);
  import rsi_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Pins float once the hold has lasted a full cycle; enables lag by one register.
  a_port_float_held: assert property (!cpuRun && !$past(cpuRun) |-> portPinOe == '0)
    else $error("port pins driven while held in reset");
  a_port_float_after: assert property (fetchStart |=> portPinOe == '0)
    else $error("port pins driven right after release");
  a_shared_float_held: assert property (!cpuRun && !$past(cpuRun) |-> sharedPinOe == '0)
    else $error("shared pins driven while held in reset");
  // The mode is latched a cycle after release and the enable lags it by one more.
  a_shared_drive_run: assert property (cpuRun && $past(cpuRun) && $past(cpuRun, 2) &&
      extModePin |-> sharedPinOe == '1)
    else $error("shared pins not driven in external mode");
  a_single_chip_float: assert property (!extModePin |-> sharedPinOe == '0)
    else $error("shared pins driven in single-chip mode");
  // Execution starts exactly one cycle after the core leaves the held state.
  a_fetch_follows_run: assert property ($rose(cpuRun) |=> fetchStart ##1 !fetchStart)
    else $error("fetch start missing after release");
  a_fetch_once: assert property (fetchStart |-> $past(cpuRun) && !$past(cpuRun, 2))
    else $error("fetch start without a release");
  a_pc_entry: assert property (fetchStart |->
      programCounter == (bootModePin ? BOOT_ENTRY : RESET_ENTRY))
    else $error("program counter not at entry address");
  a_cbr_cleared: assert property (fetchStart |-> conditionBitRegister == CBR_RESET)
    else $error("condition bit register not cleared");
  // Cleared bits are zero while the three backup bits keep their held value.
  a_psw_cleared: assert property (fetchStart |->
      (processorStatusWord & ~PSW_KEEP_MASK) == PSW_RESET &&
      (processorStatusWord & PSW_KEEP_MASK) == ($past(processorStatusWord) & PSW_KEEP_MASK))
    else $error("status word not cleared on release");
  a_ram_lost: assert property ($fell(backupOkPin) |-> ##[1:6] !ramRetained)
    else $error("RAM valid flag kept without backup supply");
endmodule : rsi_reset_state_init_chk

bind rsi_reset_state_init rsi_reset_state_init_chk chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .sharedPinOe(sharedPinOe),
  .portPinOe(portPinOe),
  .extModePin(extModePin),
  .bootModePin(bootModePin),
  .backupOkPin(backupOkPin),
  .cpuRun(cpuRun),
  .fetchStart(fetchStart),
  .programCounter(programCounter),
  .processorStatusWord(processorStatusWord),
  .conditionBitRegister(conditionBitRegister),
  .ramRetained(ramRetained)
);

// *** bench/testbench.sv ***
// Self-checking testbench of the reset state initialiser with a board reset source.
`timescale 1ns/1ns
// ============================================================================
// Testbench
module testbench;
  import rsi_pkg::*;

  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [PIN_COUNT-1:0] sharedPinIn = 17'h0a5a5;
  logic [PORT_COUNT-1:0] portPinIn = 8'h3c;
  logic busRxPinIn = 1'b0;
  logic extModePin = 1'b0;
  logic bootModePin = 1'b0;
  logic backupOkPin = 1'b1;
  logic resetPinN, xinPin, busRxIn, cpuRun, fetchStart, ramRetained;
  logic [DATA_W-1:0] regRdData, programCounter, processorStatusWord, conditionBitRegister;
  logic [PIN_COUNT-1:0] sharedPinOut, sharedPinOe;
  logic [PORT_COUNT-1:0] portPinOut, portPinOe;
  int failCount = 0;
  int numChecks = 0;

  // A 50 ns clock for the 20 MHz system domain.
  always #25 sys_clk = ~sys_clk;

  rsi_reset_source src (.resetPinN(resetPinN), .xinPin(xinPin));

  rsi_reset_state_init uut (
    .sys_clk(sys_clk), .nrst(nrst), .resetPinN(resetPinN), .xinPin(xinPin),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sharedPinIn(sharedPinIn), .sharedPinOut(sharedPinOut),
    .sharedPinOe(sharedPinOe), .portPinIn(portPinIn), .portPinOut(portPinOut),
    .portPinOe(portPinOe), .busRxPinIn(busRxPinIn), .busRxIn(busRxIn),
    .extModePin(extModePin), .bootModePin(bootModePin), .backupOkPin(backupOkPin),
    .cpuRun(cpuRun), .fetchStart(fetchStart), .programCounter(programCounter),
    .processorStatusWord(processorStatusWord),
    .conditionBitRegister(conditionBitRegister), .ramRetained(ramRetained)
  );

  // Prints the verdict in one place and ends the run.
  task automatic give_verdict();
    if (failCount == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expected);
    numChecks++;
    if (seen !== expected) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  // Bus cycles: one-cycle strobes launched right after a rising edge.
  task automatic reg_wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= addr;
    regWrData <= data;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so sample just after that edge.
  task automatic reg_rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= addr;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    data = regRdData;
  endtask : reg_rd

  // Bounded waits; running out of cycles counts a mismatch and ends the run.
  task automatic wait_fetch();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (fetchStart !== 1'b1 && n < 300);
    check(32'(fetchStart), 32'h1);
    if (fetchStart !== 1'b1) give_verdict();
  endtask : wait_fetch

  task automatic wait_held();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cpuRun !== 1'b0 && n < 300);
    check(32'(cpuRun), 32'h0);
    if (cpuRun !== 1'b0) give_verdict();
  endtask : wait_held

  // Power-on release in single-chip, normal mode.
  task automatic power_on_state();
    wait_fetch();
    check(programCounter, RESET_ENTRY);
    check(processorStatusWord, PSW_RESET);
    check(conditionBitRegister, CBR_RESET);
    check(32'(ramRetained), 32'h0);
    @(posedge sys_clk);
    #1;
    check(32'(sharedPinOe), 32'h0);
    check(32'(portPinOe), 32'h0);
  endtask : power_on_state

  // Register reads, a read-only write, an unmapped read and the receive pin path.
  task automatic register_access();
    logic [DATA_W-1:0] d;
    reg_rd(OFS_CBR, d);
    check(d, CBR_RESET);
    reg_wr(OFS_PSW, 32'h1234_5678);
    reg_rd(OFS_PSW, d);
    check(d, 32'h1234_5678);
    reg_wr(OFS_PC, 32'hdead_beef);
    reg_rd(OFS_PC, d);
    check(d, RESET_ENTRY);
    reg_rd(8'h40, d);
    check(d, 32'h0000_0000);
    // Port outputs set up here must stop driving at the next pin reset.
    reg_wr(OFS_PORT_DIR, 32'h0000_00ff);
    reg_wr(OFS_PORT_OUT, 32'h0000_00a5);
    @(posedge sys_clk);
    #1;
    check(32'(portPinOe), 32'h0000_00ff);
    check(32'(portPinOut), 32'h0000_00a5);
    @(posedge sys_clk);
    busRxPinIn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check(32'(busRxIn), 32'h1);
  endtask : register_access

  // A low pulse of only three crystal periods must leave the core running.
  task automatic short_pulse();
    int bad;
    bad = 0;
    fork
      src.hold_reset(3);
      repeat (90) begin
        @(posedge sys_clk);
        #1;
        if (cpuRun !== 1'b1 || fetchStart !== 1'b0) bad++;
      end
    join
    check(32'(bad), 32'h0);
  endtask : short_pulse

  // Pin reset into boot and external mode with backup supply present, then supply loss.
  task automatic boot_reset();
    reg_wr(OFS_PSW, 32'hffff_ffff);
    reg_wr(OFS_STATUS, 32'h0000_0004);
    fork
      src.hold_reset(6);
      begin
        wait_held();
        repeat (2) @(posedge sys_clk);
        extModePin <= 1'b1;
        bootModePin <= 1'b1;
        reg_wr(OFS_PSW, 32'h0000_0000);
        #1;
        check(32'(sharedPinOe), 32'h0);
        check(32'(portPinOe), 32'h0);
      end
    join
    wait_fetch();
    check(programCounter, BOOT_ENTRY);
    check(processorStatusWord, PSW_KEEP_MASK);
    check(conditionBitRegister, CBR_RESET);
    check(32'(ramRetained), 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(sharedPinOe), 32'h0001_ffff);
    check(32'(portPinOe), 32'h0);
    @(posedge sys_clk);
    backupOkPin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    check(32'(ramRetained), 32'h0);
  endtask : boot_reset

  // Main sequence: power-on reset for four cycles, then each scenario in turn.
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    power_on_state();
    register_access();
    short_pulse();
    boot_reset();
    give_verdict();
  end
endmodule : testbench

// *** hw/rsi_ctrl_if.sv ***
// Interface joining the reset filter, the pin control and the register core.
`timescale 1ns/1ns
interface rsi_ctrl_if;
  import rsi_pkg::*;

  logic inReset;
  logic releasePulse;
  logic extMode;
  logic [PIN_COUNT-1:0] addrValue;
  logic [IN_W-1:0] syncIn;

  modport filt (output inReset, output releasePulse);
  modport pins (input inReset, input extMode, input addrValue, output syncIn);
  modport core (input inReset, input releasePulse, output extMode, output addrValue,
    input syncIn);
endinterface : rsi_ctrl_if

// *** hw/rsi_pin_ctrl.sv ***
// Pin input synchronisers and shared address pin drivers.
`timescale 1ns/1ns
module rsi_pin_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [rsi_pkg::IN_W-1:0] rawIn,
  output logic [rsi_pkg::PIN_COUNT-1:0] sharedPinOut,
  output logic [rsi_pkg::PIN_COUNT-1:0] sharedPinOe,
  rsi_ctrl_if.pins ctl
);
  import rsi_pkg::*;

  genvar i;

  // ==========================================================================
  // Three stage synchronisers, one per pin input.
  generate
    for (i = 0; i < IN_W; i++) begin : g_sync
      logic [SYNC_STAGES-1:0] stg, next_stg;
      logic lvl, next_lvl;
      always_comb begin
        next_stg = {stg[SYNC_STAGES-2:0], rawIn[i]};
        next_lvl = (stg[1] == stg[2]) ? stg[2] : lvl;
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          stg <= '0;
          lvl <= 1'b0;
        end else begin
          stg <= next_stg;
          lvl <= next_lvl;
        end
      end
      assign ctl.syncIn[i] = lvl;
    end
  endgenerate

  // ==========================================================================
  // Shared pins float during reset; in external modes they drive the address
  // afterwards, in single-chip mode they stay inputs except for one cycle after a reset out of external mode.
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_drv
      logic oe, next_oe, dout, next_dout;
      always_comb begin
        next_oe = ctl.extMode & ~ctl.inReset;
        next_dout = ctl.addrValue[i];
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          oe <= 1'b0;
          dout <= 1'b0;
        end else begin
          oe <= next_oe;
          dout <= next_dout;
        end
      end
      assign sharedPinOe[i] = oe;
      assign sharedPinOut[i] = dout;
    end
  endgenerate

endmodule : rsi_pin_ctrl

// *** hw/rsi_pkg.sv ***
// Package of shared constants and types for the reset state initialiser.
package rsi_pkg;

  // ==========================================================================
  // Widths and pin groups
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int PIN_COUNT = 17;
  localparam int PORT_COUNT = 8;
  localparam int SYNC_STAGES = 3;

  // Positions of each pin in the synchronised input vector.
  localparam int IDX_PORT = PIN_COUNT;
  localparam int IDX_BUS_RX = PIN_COUNT + PORT_COUNT;
  localparam int IDX_EXT = IDX_BUS_RX + 1;
  localparam int IDX_BOOT = IDX_BUS_RX + 2;
  localparam int IDX_BACKUP = IDX_BUS_RX + 3;
  localparam int IN_W = PIN_COUNT + PORT_COUNT + 4;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_PSW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CBR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ISP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_USP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SPC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PC = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PORT_OUT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PORT_IN = 8'h24;

  // ==========================================================================
  // Field positions and reset values
  localparam int PSW_BSM_BIT = 15;
  localparam int PSW_BIE_BIT = 14;
  localparam int PSW_BC_BIT = 8;
  localparam logic [DATA_W-1:0] PSW_KEEP_MASK = 32'h0000_c100;
  localparam logic [DATA_W-1:0] PSW_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CBR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESET_ENTRY = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BOOT_ENTRY = 32'h8000_0000;
  localparam int STAT_EXT_BIT = 0;
  localparam int STAT_BOOT_BIT = 1;
  localparam int STAT_RAM_BIT = 2;
  localparam int STAT_BACKUP_BIT = 3;

  // ==========================================================================
  // Reset pin timing against the crystal clock input
  localparam int RST_MIN_XIN_PERIODS = 4;
  localparam int XIN_CNT_W = 3;
  localparam logic [XIN_CNT_W-1:0] RST_XIN_EDGES = 3'(RST_MIN_XIN_PERIODS + 1);

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_QUAL = 3'b010,
    ST_HELD = 3'b100
  } rsi_rst_state_t;

endpackage : rsi_pkg

// *** hw/rsi_reset_filter.sv ***
// Reset pin qualifier timed against the crystal clock input.
`timescale 1ns/1ns
module rsi_reset_filter (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic resetPinN,
  input wire logic xinPin,
  rsi_ctrl_if.filt ctl
);
  import rsi_pkg::*;

  logic [SYNC_STAGES-1:0] pinSync, next_pinSync;
  logic [SYNC_STAGES-1:0] xinSync, next_xinSync;
  logic pinLvl, next_pinLvl;
  logic xinLvl, next_xinLvl;
  logic xinRise;
  logic [XIN_CNT_W-1:0] edgeCnt, next_edgeCnt;
  logic relPulse, next_relPulse;
  rsi_rst_state_t state, next_state;

  // ==========================================================================
  // Next values
  // A level only changes once stages two and three agree, so a single
  // metastable sample never shortens or stretches the reset.
  always_comb begin
    next_pinSync = {pinSync[SYNC_STAGES-2:0], resetPinN};
    next_xinSync = {xinSync[SYNC_STAGES-2:0], xinPin};
    next_pinLvl = (pinSync[1] == pinSync[2]) ? pinSync[2] : pinLvl;
    next_xinLvl = (xinSync[1] == xinSync[2]) ? xinSync[2] : xinLvl;
    xinRise = ~xinLvl & xinSync[1] & xinSync[2];
    next_state = state;
    next_edgeCnt = edgeCnt;
    next_relPulse = 1'b0;
    unique case (state)
      ST_RUN: begin
        if (!pinLvl) begin
          next_state = ST_QUAL;
          next_edgeCnt = '0;
        end
      end
      ST_QUAL: begin
        // A low shorter than the crystal periods is ignored.
        if (pinLvl) begin
          next_state = ST_RUN;
        end else if (xinRise) begin
          next_edgeCnt = XIN_CNT_W'(edgeCnt + 1'b1);
          if (XIN_CNT_W'(edgeCnt + 1'b1) == RST_XIN_EDGES) begin
            next_state = ST_HELD;
          end
        end
      end
      ST_HELD: begin
        // Rising reset pin ends the held state and fires the vector load.
        if (pinLvl) begin
          next_state = ST_RUN;
          next_relPulse = 1'b1;
        end
      end
      default: begin
        next_state = ST_HELD;
      end
    endcase
  end

  // ==========================================================================
  // Registers; power-on starts in the held state.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinSync <= '0;
      xinSync <= '0;
      pinLvl <= 1'b0;
      xinLvl <= 1'b0;
      edgeCnt <= '0;
      relPulse <= 1'b0;
      state <= ST_HELD;
    end else begin
      pinSync <= next_pinSync;
      xinSync <= next_xinSync;
      pinLvl <= next_pinLvl;
      xinLvl <= next_xinLvl;
      edgeCnt <= next_edgeCnt;
      relPulse <= next_relPulse;
      state <= next_state;
    end
  end

  assign ctl.inReset = (state == ST_HELD);
  assign ctl.releasePulse = relPulse;

endmodule : rsi_reset_filter

// *** hw/rsi_reset_state_init.sv ***
// Register core that sets processor state and pin state around reset.
`timescale 1ns/1ns

// ============================================================================
// Overview of operation
// - On release, status word clears except three backup bits, which keep old value.
// - On release, condition bit register holds all zeros.
// - Outside boot mode, program counter loads zero on release.
// - In boot mode, program counter loads boot space start on release.
// - RAM kept across reset while backup supply in range; lost at power-on.
// - Port pins left as inputs by reset float during and after reset.
// - External modes: shared address pins float in reset, then drive.
// - Single-chip mode: shared pins stay floating port inputs, except one cycle after a reset out of external mode.
// - Reset pin rising loads the entry address and starts execution.
// - Bus receive pin is input only and always floats.
module rsi_reset_state_init (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic resetPinN,
  input wire logic xinPin,
  input wire logic [rsi_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rsi_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [rsi_pkg::DATA_W-1:0] regRdData,
  input wire logic [rsi_pkg::PIN_COUNT-1:0] sharedPinIn,
  output logic [rsi_pkg::PIN_COUNT-1:0] sharedPinOut,
  output logic [rsi_pkg::PIN_COUNT-1:0] sharedPinOe,
  input wire logic [rsi_pkg::PORT_COUNT-1:0] portPinIn,
  output logic [rsi_pkg::PORT_COUNT-1:0] portPinOut,
  output logic [rsi_pkg::PORT_COUNT-1:0] portPinOe,
  input wire logic busRxPinIn,
  output logic busRxIn,
  input wire logic extModePin,
  input wire logic bootModePin,
  input wire logic backupOkPin,
  output logic cpuRun,
  output logic fetchStart,
  output logic [rsi_pkg::DATA_W-1:0] programCounter,
  output logic [rsi_pkg::DATA_W-1:0] processorStatusWord,
  output logic [rsi_pkg::DATA_W-1:0] conditionBitRegister,
  output logic ramRetained
);
  import rsi_pkg::*;

  rsi_ctrl_if ctl ();

  // ==========================================================================
  // Reset qualification and pin handling
  rsi_reset_filter u_filter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .resetPinN(resetPinN),
    .xinPin(xinPin),
    .ctl(ctl.filt)
  );

  rsi_pin_ctrl u_pins (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .rawIn({backupOkPin, bootModePin, extModePin, busRxPinIn, portPinIn, sharedPinIn}),
    .sharedPinOut(sharedPinOut),
    .sharedPinOe(sharedPinOe),
    .ctl(ctl.pins)
  );

  // ==========================================================================
  // State registers
  logic [DATA_W-1:0] processor_status_word, next_psw;
  logic [DATA_W-1:0] condition_bit_register, next_cbr;
  logic [DATA_W-1:0] isp, next_isp;
  logic [DATA_W-1:0] usp, next_usp;
  logic [DATA_W-1:0] spc, next_spc;
  logic [DATA_W-1:0] pc, next_pc;
  logic [PORT_COUNT-1:0] portDir, next_portDir;
  logic [PORT_COUNT-1:0] portOut, next_portOut;
  logic [PORT_COUNT-1:0] portOe, next_portOe;
  logic [PORT_COUNT-1:0] portDrv, next_portDrv;
  logic ramValid, next_ramValid;
  logic extMode, next_extMode;
  logic bootMode, next_bootMode;
  logic fetchPulse, next_fetchPulse;
  logic [DATA_W-1:0] rdData, next_rdData;
  logic wrOk;
  logic backupOk;
  logic [DATA_W-1:0] statusWord;

  // Writes are held off while the device sits in reset.
  assign wrOk = regWr & ~ctl.inReset;
  assign backupOk = ctl.syncIn[IDX_BACKUP];

  // Status view of the block's own state.
  always_comb begin
    statusWord = '0;
    statusWord[STAT_EXT_BIT] = extMode;
    statusWord[STAT_BOOT_BIT] = bootMode;
    statusWord[STAT_RAM_BIT] = ramValid;
    statusWord[STAT_BACKUP_BIT] = backupOk;
  end

  // ==========================================================================
  // Processor register next values
  // The release pulse has priority over software, since the processor does
  // not start fetching until the cycle after it.
  always_comb begin
    next_psw = processor_status_word;
    next_cbr = condition_bit_register;
    next_isp = isp;
    next_usp = usp;
    next_spc = spc;
    next_pc = pc;
    next_fetchPulse = 1'b0;
    if (ctl.releasePulse) begin
      next_psw = (processor_status_word & PSW_KEEP_MASK) | (PSW_RESET & ~PSW_KEEP_MASK);
      next_cbr = CBR_RESET;
      if (ctl.syncIn[IDX_BOOT]) begin
        next_pc = BOOT_ENTRY;
      end else begin
        next_pc = RESET_ENTRY;
      end
      next_fetchPulse = 1'b1;
    end else if (wrOk) begin
      unique case (regAddr)
        OFS_PSW: next_psw = regWrData;
        OFS_CBR: next_cbr = regWrData;
        OFS_ISP: next_isp = regWrData;
        OFS_USP: next_usp = regWrData;
        OFS_SPC: next_spc = regWrData;
        default: begin
        end
      endcase
    end
  end

  // Stack pointers and the saved counter are left untouched by a pin reset;
  // only power-on gives them a value.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      processor_status_word <= PSW_RESET;
      condition_bit_register <= CBR_RESET;
      isp <= '0;
      usp <= '0;
      spc <= '0;
      pc <= RESET_ENTRY;
      fetchPulse <= 1'b0;
    end else begin
      processor_status_word <= next_psw;
      condition_bit_register <= next_cbr;
      isp <= next_isp;
      usp <= next_usp;
      spc <= next_spc;
      pc <= next_pc;
      fetchPulse <= next_fetchPulse;
    end
  end

  // ==========================================================================
  // Mode straps and RAM retention next values
  // Straps are caught on the release pulse, never by the asynchronous reset.
  always_comb begin
    next_extMode = extMode;
    next_bootMode = bootMode;
    next_ramValid = ramValid;
    if (ctl.releasePulse) begin
      next_extMode = ctl.syncIn[IDX_EXT];
      next_bootMode = ctl.syncIn[IDX_BOOT];
    end
    // Losing the backup supply always wins over software marking RAM valid,
    // because contents written then cannot be trusted.
    if (!backupOk) begin
      next_ramValid = 1'b0;
    end else if (wrOk && regAddr == OFS_STATUS && regWrData[STAT_RAM_BIT]) begin
      next_ramValid = 1'b1;
    end
  end

  // Power-on clears the RAM valid flag; a pin reset leaves it alone.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extMode <= 1'b0;
      bootMode <= 1'b0;
      ramValid <= 1'b0;
    end else begin
      extMode <= next_extMode;
      bootMode <= next_bootMode;
      ramValid <= next_ramValid;
    end
  end

  // ==========================================================================
  // Port pin next values
  // Direction clears on release so every port pin starts as an input.
  always_comb begin
    next_portDir = portDir;
    next_portOut = portOut;
    if (ctl.releasePulse) begin
      next_portDir = '0;
    end else if (wrOk && regAddr == OFS_PORT_DIR) begin
      next_portDir = regWrData[PORT_COUNT-1:0];
    end else if (wrOk && regAddr == OFS_PORT_OUT) begin
      next_portOut = regWrData[PORT_COUNT-1:0];
    end
    // Drivers are gated by reset and follow the new direction, so an old
    // output setting never drives for a cycle after release.
    next_portOe = next_portDir & {PORT_COUNT{~ctl.inReset}};
    next_portDrv = portOut;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      portDir <= '0;
      portOut <= '0;
      portOe <= '0;
      portDrv <= '0;
    end else begin
      portDir <= next_portDir;
      portOut <= next_portOut;
      portOe <= next_portOe;
      portDrv <= next_portDrv;
    end
  end

  // ==========================================================================
  // Register read port
  // Data stands only in the cycle after the strobe; unmapped reads give zero.
  always_comb begin
    next_rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        OFS_PSW: next_rdData = processor_status_word;
        OFS_CBR: next_rdData = condition_bit_register;
        OFS_ISP: next_rdData = isp;
        OFS_USP: next_rdData = usp;
        OFS_SPC: next_rdData = spc;
        OFS_PC: next_rdData = pc;
        OFS_STATUS: next_rdData = statusWord;
        OFS_PORT_DIR: next_rdData = DATA_W'(portDir);
        OFS_PORT_OUT: next_rdData = DATA_W'(portOut);
        OFS_PORT_IN: next_rdData = DATA_W'(ctl.syncIn[IDX_PORT +: PORT_COUNT]);
        default: next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ==========================================================================
  // Outputs
  // In external modes the shared pins carry the low address bits; their
  // level right after release is not meaningful to the board.
  assign ctl.extMode = extMode;
  assign ctl.addrValue = pc[PIN_COUNT-1:0];

  // The receive pin is only ever sampled; it has no driver at all.
  assign busRxIn = ctl.syncIn[IDX_BUS_RX];

  assign regRdData = rdData;
  assign portPinOe = portOe;
  assign portPinOut = portDrv;
  assign cpuRun = ~ctl.inReset;
  assign fetchStart = fetchPulse;
  assign programCounter = pc;
  assign processorStatusWord = processor_status_word;
  assign conditionBitRegister = condition_bit_register;
  assign ramRetained = ramValid;

endmodule : rsi_reset_state_init
